// *** shared_reset_defines.vh ***
// Constants for the shared reset and boot mode selector.
`ifndef SHARED_RESET_DEFINES_VH
`define SHARED_RESET_DEFINES_VH
`define BOOT_CODE_PARALLEL   4'h0
`define BOOT_CODE_RAM        4'h1
`define BOOT_CODE_SERIAL     4'h2
`define BOOT_CODE_CAN        4'h3
`define BOOT_CODE_ETHERNET   4'h4
`define BOOT_CODE_OTP        4'h6
`define BOOT_CODE_FLASH      4'h7
`define BOOT_CODE_SSI_MASTER 4'h9
`define BOOT_CODE_I2C_MASTER 4'hA
`define BOOT_MODE_PARALLEL   4'h0
`define BOOT_MODE_RAM        4'h1
`define BOOT_MODE_SERIAL     4'h2
`define BOOT_MODE_CAN        4'h3
`define BOOT_MODE_ETHERNET   4'h4
`define BOOT_MODE_OTP        4'h6
`define BOOT_MODE_FLASH      4'h7
`define BOOT_MODE_SSI_MASTER 4'h9
`define BOOT_MODE_I2C_MASTER 4'hA
`define BOOT_MODE_RESET      4'h7
`define SEQ_IDLE             3'h0
`define SEQ_DEVICE_INIT      3'h1
`define SEQ_MASTER_INIT      3'h2
`define SEQ_RELEASE          3'h3
`define SEQ_SAMPLE           3'h4
`define SEQ_BRANCH           3'h5
`endif

// *** shared_reset_boot.v ***
// Shared reset combiner and master boot sequence with strap decode.
`include "shared_reset_defines.vh"
module shared_reset_boot #(
  // Length of the device-level initialisation phase in clocks.
  // The phase counter is eight bits wide, so this must not exceed 256.
  parameter DEVICE_INIT_CYCLES = 8,
  // Length of the master initialisation phase in clocks, same limit.
  // Both phases stand in for firmware work and only set the pacing.
  parameter MASTER_INIT_CYCLES = 8,
  // Set for the earliest silicon: top strap ignored and no remapping.
  // Codes eight to fifteen on the pins are then read as codes zero to seven.
  parameter EARLY_REVISION     = 0,
  // Set for test-grade parts, which alone may boot from the OTP area.
  // On every other part code six behaves like the flash code.
  parameter TEST_GRADE         = 0
) (
  input  wire       sys_clk,
  input  wire       rst,
  // Reset pins, active low and asynchronous to sys_clk.
  input  wire       external_reset_pin_n,
  input  wire       analog_reset_pin_n,
  // Reset requests from the master side, already on sys_clk.
  input  wire       master_software_reset,
  input  wire       master_debugger_reset,
  input  wire       master_watchdog_reset,
  input  wire       master_nmi_watchdog_reset,
  input  wire       reset_propagate_enable,
  input  wire       analog_bus_reset,
  // Boot strap pins and the optional alternate code, static during a boot.
  input  wire       boot_select_bit3,
  input  wire       boot_select_bit2,
  input  wire       boot_select_bit1,
  input  wire       boot_select_bit0,
  input  wire       boot_pin_remap_enable,
  input  wire [3:0] boot_pin_remap,
  // Handshakes from the master application after the boot.
  input  wire       master_to_control_wake_interrupt,
  input  wire       application_ready,
  // Reset outputs, each taken straight from a flip-flop.
  output reg        shared_analog_reset,
  output reg        analog_subsystem_reset,
  output reg        shared_resource_reset,
  output reg        master_system_reset,
  output reg        external_parallel_port_reset,
  output reg        control_subsystem_reset,
  // Sequencer status and the latched boot mode.
  output reg        control_idle,
  output reg        master_boot_start,
  output reg        device_init_active,
  output reg        master_init_active,
  output reg        boot_mode_valid,
  output reg  [3:0] boot_mode,
  output reg        branch_to_application
);
  // Synchronised copies of the asynchronous pin and strap inputs.
  // Bit zero of each pair is only ever read by bit one, so a metastable
  // first stage has a whole clock to settle before logic sees it.
  reg [1:0] xrs_sync;
  reg [1:0] ars_sync;
  reg [1:0] b3_sync;
  reg [1:0] b2_sync;
  reg [1:0] b1_sync;
  reg [1:0] b0_sync;
  reg [1:0] remap_sync;
  reg [3:0] remap_val_sync0;
  reg [3:0] remap_val_sync1;
  // Boot sequencer state, its phase counter and the delayed master reset.
  // The delayed copy lets the idle state see the falling edge of reset.
  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] count;
  reg       master_reset_prev;
  // Combined reset terms and the strap code before and after revision masking.
  // These are plain gates; every output below is registered from them.
  wire      xrs_active;
  wire      ars_active;
  wire      shared_src;
  wire      master_src;
  wire [3:0] raw_code;
  wire [3:0] code;

  // Map a four-bit boot code onto the mode that the boot program runs.
  // The mode encoding equals the code for every supported entry, and all
  // unsupported codes land on the flash mode, which is also the value the
  // mode output shows while the master is held in reset.
  // The early flag removes the two bus-master loaders, and the test flag
  // is the only way code six reaches the OTP mode.
  function [3:0] decode_mode;
    input [3:0] c;
    input       early;
    input       test_part;
    begin
      decode_mode = `BOOT_MODE_FLASH;
      if (c == `BOOT_CODE_PARALLEL) begin
        decode_mode = `BOOT_MODE_PARALLEL;
      end else if (c == `BOOT_CODE_RAM) begin
        decode_mode = `BOOT_MODE_RAM;
      end else if (c == `BOOT_CODE_SERIAL) begin
        decode_mode = `BOOT_MODE_SERIAL;
      end else if (c == `BOOT_CODE_CAN) begin
        decode_mode = `BOOT_MODE_CAN;
      end else if (c == `BOOT_CODE_ETHERNET) begin
        decode_mode = `BOOT_MODE_ETHERNET;
      end else if (c == `BOOT_CODE_OTP && test_part) begin
        decode_mode = `BOOT_MODE_OTP;
      end else if (c == `BOOT_CODE_FLASH) begin
        decode_mode = `BOOT_MODE_FLASH;
      end else if (c == `BOOT_CODE_SSI_MASTER && !early) begin
        decode_mode = `BOOT_MODE_SSI_MASTER;
      end else if (c == `BOOT_CODE_I2C_MASTER && !early) begin
        decode_mode = `BOOT_MODE_I2C_MASTER;
      end
    end
  endfunction

  // Two-stage synchronisers for every pin-level input.
  // The reset pins are inverted on entry so that a high bit means active.
  // The alternate code is a four-bit word that passes the stages as a word;
  // this is safe only because it is static long before the straps are read,
  // and the enable that selects it is synchronised on its own.
  // None of these flops is reset: they simply follow their pins.
  always @(posedge sys_clk) begin
    xrs_sync        <= {xrs_sync[0], ~external_reset_pin_n};
    ars_sync        <= {ars_sync[0], ~analog_reset_pin_n};
    b3_sync         <= {b3_sync[0], boot_select_bit3};
    b2_sync         <= {b2_sync[0], boot_select_bit2};
    b1_sync         <= {b1_sync[0], boot_select_bit1};
    b0_sync         <= {b0_sync[0], boot_select_bit0};
    remap_sync      <= {remap_sync[0], boot_pin_remap_enable};
    remap_val_sync0 <= boot_pin_remap;
    remap_val_sync1 <= remap_val_sync0;
  end

  // The reset input acts like the external pin, so both feed every chain.
  // The analog pin only reaches the analog subsystem reset.
  // Pin levels are used only after both synchroniser stages.
  assign xrs_active = xrs_sync[1] | rst;
  assign ars_active = ars_sync[1];
  // Software and debugger resets only count once propagation is enabled.
  // Before the master enables it, these two requests leave both shared resets low,
  // though through the master reset they still hold the control and analog subsystems.
  assign shared_src = xrs_active |
                      (reset_propagate_enable &
                       (master_software_reset | master_debugger_reset));
  // The master reset takes every source except the analog pin and the analog bus reset, watchdogs included, unmasked.
  // Any of them restarts the boot sequence once it goes away.
  assign master_src = xrs_active | master_software_reset | master_debugger_reset |
                      master_watchdog_reset | master_nmi_watchdog_reset;

  // Strap code, pin four on top; remap only on the later revision.
  // The code is read continuously but only captured in the sample state,
  // so only the strap level sampled two clocks before that capture, through the synchroniser, has any effect.
  // The early revision forces the top bit low whatever the pin shows.
  assign raw_code = (remap_sync[1] && !EARLY_REVISION) ? remap_val_sync1 :
                    {b3_sync[1], b2_sync[1], b1_sync[1], b0_sync[1]};
  assign code     = EARLY_REVISION ? {1'b0, raw_code[2:0]} : raw_code;

  // Reset outputs driven from flip-flops.
  // Each output lags its sources by one clock, which keeps every top-level
  // output glitch free at the cost of a cycle of latency.
  // The parallel port follows the master reset, never the shared one.
  always @(posedge sys_clk) begin
    shared_analog_reset          <= shared_src;
    shared_resource_reset        <= shared_src;
    master_system_reset          <= master_src;
    external_parallel_port_reset <= master_src;
    master_reset_prev            <= master_src;
  end

  // Boot sequencer state register.
  // The counter restarts on every state change, so each timed phase
  // lasts exactly its parameter in clocks.
  // Any master reset source returns the sequencer to idle at once.
  always @(posedge sys_clk) begin
    if (master_src) begin
      state <= `SEQ_IDLE;
      count <= 8'h00;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        count <= 8'h00;
      end else begin
        count <= count + 8'h01;
      end
    end
  end

  // Next-state selection in the boot order.
  // Idle waits for the clock after the master reset goes inactive, then
  // the two timed phases run, then release, sample and branch follow one
  // clock each; branch is the resting state until the next reset.
  always @* begin
    next_state = state;
    case (state)
      `SEQ_IDLE: begin
        if (master_reset_prev) begin
          next_state = `SEQ_DEVICE_INIT;
        end
      end
      `SEQ_DEVICE_INIT: begin
        if (count == DEVICE_INIT_CYCLES - 1) begin
          next_state = `SEQ_MASTER_INIT;
        end
      end
      `SEQ_MASTER_INIT: begin
        if (count == MASTER_INIT_CYCLES - 1) begin
          next_state = `SEQ_RELEASE;
        end
      end
      // Release lasts one clock; the output process frees control then.
      `SEQ_RELEASE: begin
        next_state = `SEQ_SAMPLE;
      end
      // The straps are captured during this single clock.
      `SEQ_SAMPLE: begin
        next_state = `SEQ_BRANCH;
      end
      // Branch and the unused codes all settle in the branch state.
      default: begin
        next_state = `SEQ_BRANCH;
      end
    endcase
  end

  // Sequencer outputs, subsystem holds and the latched boot mode.
  // During any master reset the control and analog subsystems are held,
  // the mode shows the flash fallback and every status flag is low.
  // When release and the wake interrupt meet in one clock, release wins
  // and the control processor is left idle.
  always @(posedge sys_clk) begin
    if (master_src) begin
      control_subsystem_reset <= 1'b1;
      analog_subsystem_reset  <= 1'b1;
      control_idle            <= 1'b0;
      master_boot_start       <= 1'b0;
      device_init_active      <= 1'b0;
      master_init_active      <= 1'b0;
      boot_mode_valid         <= 1'b0;
      boot_mode               <= `BOOT_MODE_RESET;
      branch_to_application   <= 1'b0;
    end else begin
      master_boot_start  <= (state == `SEQ_IDLE) && master_reset_prev;
      device_init_active <= (next_state == `SEQ_DEVICE_INIT);
      master_init_active <= (next_state == `SEQ_MASTER_INIT);
      if (state == `SEQ_RELEASE) begin
        control_subsystem_reset <= 1'b0;
        control_idle            <= 1'b1;
      end else if (master_to_control_wake_interrupt) begin
        control_idle <= 1'b0;
      end
      // Analog stays held by shared reset, bus reset or its own pin.
      analog_subsystem_reset <= shared_src | analog_bus_reset | ars_active |
                                (state != `SEQ_SAMPLE && state != `SEQ_BRANCH &&
                                 analog_subsystem_reset);
      if (state == `SEQ_SAMPLE && !boot_mode_valid) begin
        boot_mode       <= decode_mode(code, EARLY_REVISION != 0, TEST_GRADE != 0);
        boot_mode_valid <= 1'b1;
      end
      // The branch waits for both a captured mode and resident application code.
      branch_to_application <= boot_mode_valid && application_ready;
    end
  end
endmodule

// *** board_model.sv ***
// Board side model driving the reset pin and the boot strap levels.
module board_model (
  input  wire       sys_clk,
  input  wire       hold_reset,
  input  wire [3:0] strap,
  output reg        pin_n,
  output wire [3:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  integer left = 8;
  initial pin_n = 1'b0;
  // Each request keeps the pin low for eight more clocks after it ends.
  // The request is driven on the falling edge, so it is read on the rising one.
  always @(posedge sys_clk) begin
    left <= hold_reset ? 8 : (left > 0 ? left - 1 : 0);
    pin_n <= !(hold_reset || left > 0);
  end
  // The straps are always at a defined level, never left floating.
  assign pins = strap;
endmodule

// *** shared_reset_boot_asserts.sv ***
// Port assertions for the shared reset and boot selector.
module shared_reset_boot_asserts (
  input wire       sys_clk, rst, master_software_reset, master_debugger_reset,
  input wire       reset_propagate_enable, shared_analog_reset, shared_resource_reset,
  input wire       master_system_reset, external_parallel_port_reset,
  input wire       control_subsystem_reset, master_boot_start, device_init_active,
  input wire       master_init_active, boot_mode_valid,
  input wire [3:0] boot_mode
);
  // All checks use the one clock and rest while reset is high.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_shared_gate: assert property (reset_propagate_enable &&
    (master_software_reset || master_debugger_reset) |=> shared_analog_reset) else $error("gate");
  a_shared_pair: assert property (
    shared_resource_reset == shared_analog_reset) else $error("shared pair");
  a_port_pair: assert property (
    external_parallel_port_reset == master_system_reset) else $error("port reset");
  a_boot_start: assert property (
    $fell(master_system_reset) |-> ##[0:2] master_boot_start) else $error("boot start");
  a_hold_ctrl: assert property (!control_subsystem_reset |->
    !device_init_active && !master_init_active) else $error("early release");
  a_mode_after: assert property (
    boot_mode_valid |-> !control_subsystem_reset) else $error("mode before release");
  a_mode_hold: assert property (boot_mode_valid && $past(boot_mode_valid)
    |-> $stable(boot_mode)) else $error("mode moved");
  a_mode_legal: assert property (boot_mode_valid |->
    boot_mode inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h9, 4'hA}) else $error("mode");
  // Main scenarios seen.
  c_start: cover property (master_boot_start);
  c_i2c: cover property (boot_mode_valid && boot_mode == 4'hA);
  c_flash: cover property (boot_mode_valid && boot_mode == 4'h7);
endmodule
bind shared_reset_boot shared_reset_boot_asserts chk_i (.sys_clk, .rst,
  .master_software_reset, .master_debugger_reset, .reset_propagate_enable,
  .shared_analog_reset, .shared_resource_reset, .master_system_reset,
  .external_parallel_port_reset, .control_subsystem_reset, .master_boot_start,
  .device_init_active, .master_init_active, .boot_mode_valid, .boot_mode);

// *** shared_reset_boot_bench.sv ***
// Self-checking bench for the shared reset and boot selector.
`include "shared_reset_defines.vh"
module shared_reset_boot_bench;
  timeunit 1ns;
  timeprecision 1ps;
  reg sys_clk = 1'b0, rst = 1'b1, sw = 1'b0, dbg = 1'b0, wd = 1'b0, nmi = 1'b0;
  reg en = 1'b0, bus = 1'b0, wake = 1'b0, rdy = 1'b0, hold = 1'b1, remap_en = 1'b0;
  reg [3:0] strap = 4'h0, remap_val = 4'h0;
  wire pin_n, sar, asr, idle, vld, br;
  wire [3:0] pins, mode;
  integer err_count = 0, cmp_count = 0, seed = 56342, i, k, r;
  board_model brd (.sys_clk(sys_clk), .hold_reset(hold), .strap(strap), .pin_n(pin_n),
    .pins(pins));
  shared_reset_boot #(.DEVICE_INIT_CYCLES(2), .MASTER_INIT_CYCLES(2)) dut (
    .sys_clk(sys_clk), .rst(rst), .external_reset_pin_n(pin_n), .analog_reset_pin_n(pin_n),
    .master_software_reset(sw), .master_debugger_reset(dbg), .master_watchdog_reset(wd),
    .master_nmi_watchdog_reset(nmi), .reset_propagate_enable(en), .analog_bus_reset(bus),
    .boot_select_bit3(pins[3]), .boot_select_bit2(pins[2]), .boot_select_bit1(pins[1]),
    .boot_select_bit0(pins[0]), .boot_pin_remap_enable(remap_en), .boot_pin_remap(remap_val),
    .master_to_control_wake_interrupt(wake), .application_ready(rdy),
    .shared_analog_reset(sar), .analog_subsystem_reset(asr), .shared_resource_reset(),
    .master_system_reset(), .external_parallel_port_reset(), .control_subsystem_reset(),
    .control_idle(idle), .master_boot_start(), .device_init_active(),
    .master_init_active(), .boot_mode_valid(vld), .boot_mode(mode),
    .branch_to_application(br));
  // Clock of 4 ns period.
  always #2 sys_clk = ~sys_clk;
  // Reference decode: supported codes map to themselves, the rest to flash.
  function [3:0] exp_mode(input [3:0] c);
    exp_mode = (c < 4'h5 || c == 4'h7 || c == 4'h9 || c == 4'hA) ? c : `BOOT_MODE_FLASH;
  endfunction
  task cyc(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  task chk(input [3:0] got, input [3:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wait_valid;
    begin
      k = 0;
      while (vld !== 1'b1 && k < 200) begin
        cyc(1);
        k = k + 1;
      end
      chk(vld, 1'b1);
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Boot once per code, each time after one of the four master-side reset requests in turn.
  initial begin
    cyc(16);
    rst = 1'b0;
    hold = 1'b0;
    wait_valid;
    for (i = 0; i < 16; i = i + 1) begin
      r = $random(seed);
      strap = i[3:0];
      en = r[0];
      rdy = r[1];
      {wd, nmi, dbg, sw} = 4'h1 << i[1:0];
      cyc(1);
      chk(sar, en & (sw | dbg));
      cyc(1);
      chk(vld, 1'b0);
      {wd, nmi, dbg, sw} = 4'h0;
      wait_valid;
      chk(mode, exp_mode(i[3:0]));
      chk(idle, 1'b1);
      strap = ~strap;
      bus = 1'b1;
      wake = 1'b1;
      cyc(2);
      chk(idle, 1'b0);
      chk(asr, 1'b1);
      chk(br, rdy);
      chk(mode, exp_mode(i[3:0]));
      bus = 1'b0;
      wake = 1'b0;
    end
    remap_en = 1'b1;
    remap_val = 4'h9;
    strap = 4'h3;
    sw = 1'b1;
    cyc(2);
    sw = 1'b0;
    wait_valid;
    chk(mode, 4'h9);
    remap_en = 1'b0;
    strap = 4'hA;
    hold = 1'b1;
    cyc(1);
    hold = 1'b0;
    cyc(5);
    chk(sar, 1'b1);
    wait_valid;
    chk(mode, 4'hA);
    report_and_stop;
  end
  // Cuts a hang short.
  initial begin
    #20000;
    err_count = err_count + 1;
    report_and_stop;
  end
endmodule
